// ==== smbarp_pkg.sv ====
// Constants and types shared by the address-resolution identity block
package smbarp_pkg;

   // ****************************************
   // Bus protocol constants
   // ****************************************
   localparam logic [6:0] ARP_ADDR = 7'h61;
   localparam logic [7:0] CMD_PREPARE = 8'h01;
   localparam logic [7:0] CMD_RESET_GEN = 8'h02;
   localparam logic [7:0] CMD_GET_GEN = 8'h03;
   localparam logic [7:0] CMD_ASSIGN = 8'h04;
   localparam logic [7:0] UDID_COUNT = 8'h11;
   localparam logic [7:0] NO_ADDR_BYTE = 8'hff;
   localparam logic [7:0] IDLE_BYTE = 8'hff;

   // ****************************************
   // Byte positions within a transaction
   // ****************************************
   localparam logic [4:0] IDX_CNT = 5'h01;
   localparam logic [4:0] IDX_UDID_LAST = 5'h11;
   localparam logic [4:0] IDX_ASN_ADDR = 5'h12;
   localparam logic [4:0] IDX_GEN_END = 5'h02;
   localparam logic [4:0] IDX_ASN_END = 5'h14;
   localparam logic [4:0] IDX_TX_ADDR = 5'h11;
   localparam logic [4:0] IDX_TX_PEC = 5'h12;
   localparam logic [4:0] UDID_NBYTES = 5'h10;

   // ****************************************
   // Identifier fields
   // ****************************************
   localparam logic [7:0] UDID_CAP = 8'hc1;
   localparam logic [15:0] UDID_IFACE = 16'h0004;
   localparam logic [31:0] UDID_SUBSYS = 32'h0000_0000;
   localparam logic [12:0] UDID_VS_PAD = 13'h0000;
   localparam logic [6:0] FD_ADDR_BASE = 7'h50;
   localparam logic [7:0] PEC_POLY = 8'h07;

   // ****************************************
   // Power-up capture and random source
   // ****************************************
   localparam logic [1:0] STRAP_SETTLE = 2'h3;
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   localparam logic [15:0] LFSR_TAPS = 16'hb400;

   // ****************************************
   // Register map and fields
   // ****************************************
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_RAND = 4'h8;
   localparam int CTRL_EN = 0;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam int ST_FD = 0;
   localparam int ST_AR = 1;
   localparam int ST_AV = 2;
   localparam int ST_STRAP_DONE = 3;
   localparam int ST_LVL = 4;
   localparam int ST_PEC_ERR = 7;
   localparam int ST_ADDR = 8;
   localparam int ST_RND_DONE = 15;

   typedef enum {S_IDLE, S_RX, S_RXACK, S_TX, S_TXACK} smbarp_state_t;

endpackage

// ==== smbarp_sync.sv ====
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module smbarp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } smbarp_sync_t;

   smbarp_sync_t r;
   smbarp_sync_t r_nxt;

   always_comb begin
      r_nxt = r;
      r_nxt.s1 = d;
      r_nxt.s2 = r.s1;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign q = r.s2;
endmodule

// ==== smbarp_crc8.sv ====
// Packet error code update over one byte
`timescale 1ns/1ps
module smbarp_crc8
   import smbarp_pkg::*;
(
   input wire logic [7:0] crc,
   input wire logic [7:0] data,
   output logic [7:0] crc_nxt
);
   always_comb begin
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++) begin
         c = c[7] ? ((c << 1) ^ PEC_POLY) : (c << 1);
      end
      crc_nxt = c;
   end
endmodule

// ==== smbarp_udid.sv ====
// Address-resolution responder with identifier, strap capture and registers
//
// The Avalon-MM slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Hold a 128-bit identifier and return it on get-identifier.
// - Vendor-specific part carries a random value so twin devices differ.
// - Every resolution exchange carries PEC; device generates and checks it.
// - Broadcast commands reach all; directed ones need an assigned address.
// - Prepare-to-resolve accepted only as broadcast.
// - Reset-device accepted broadcast and directed at own address.
// - Get-identifier answered broadcast while address-resolved flag clear, and directed, with full identifier.
// - Upper four strap levels pick resolution mode, strap_level_input 111 to 100.
// - Lower four strap levels pick fixed mode, address 0x53 to 0x50.
// - Identifier bits 127:120 hold capability byte 11000001.
// - Bits 119:112 hold format version 1 with silicon revision.
// - Bits 111:96 vendor code, bits 95:80 device code, both constant.
// - Bits 79:64 hold interface field encoding SMBus 2.0.
// - Subsystem vendor and device fields read as zero.
// - Bits 31:0 are zeros, three strap_level_input bits (zeros in fixed mode), then 16-bit random.
// - Fixed mode supports all commands but assign; address never changes.
// - Strap captured once at power-up; later changes ignored.
module smbarp_udid
   import smbarp_pkg::*;
#(
   parameter logic [7:0] VER_REV = 8'h08,     // Arbitrary revision value
   parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'h5678  // Arbitrary value
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic [2:0] strap_level_input,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic fixed_discoverable_mode,
   output logic [6:0] slave_addr,
   output logic addr_valid
);
   typedef struct packed {
      logic scl_q;
      logic sda_q;
      smbarp_state_t st;
      logic [2:0] bitcnt;
      logic [7:0] sh;
      logic [7:0] tx;
      logic [4:0] bidx;
      logic addrph;
      logic got8;
      logic ackgo;
      logic rd;
      logic [7:0] cmd;
      logic cmd_ok;
      logic in_xfer;
      logic [7:0] crc;
      logic pec_ok;
      logic match;
      logic [6:0] new_addr;
      logic sda_oe_n;
      logic sda_out;
      logic ar;
      logic av;
      logic [6:0] my_addr;
      logic fd_mode;
      logic [2:0] strap_position_bits;
      logic strap_done;
      logic [1:0] settle;
      logic [15:0] lfsr;
      logic [15:0] rnd;
      logic rnd_done;
      logic resp_en;
      logic pec_err;
      logic wreq;
      logic [31:0] rdata;
   } smbarp_udid_t;

   smbarp_udid_t r;
   smbarp_udid_t r_nxt;

   logic scl_s;
   logic sda_s;
   logic [2:0] strap_s;
   logic [7:0] rx_byte;
   logic [7:0] crc_rx;
   logic [7:0] crc_tx;
   logic [7:0] tx_byte;
   logic [4:0] tx_idx;
   logic [127:0] udid;
   logic [7:0] addr_byte;
   logic cmd_valid;
   logic start;
   logic stop;
   logic rise;
   logic fall;

   // ****************************************
   // Pin synchronisers and PEC calculators
   // ****************************************
   smbarp_sync #(.W(5)) u_sync (
      .clk(clk),
      .reset(reset),
      .d({scl_in, sda_in, strap_level_input}),
      .q({scl_s, sda_s, strap_s})
   );

   smbarp_crc8 u_crc_rx (
      .crc(r.crc),
      .data(rx_byte),
      .crc_nxt(crc_rx)
   );

   smbarp_crc8 u_crc_tx (
      .crc(r.crc),
      .data(tx_byte),
      .crc_nxt(crc_tx)
   );

   function automatic logic [7:0] udid_sel(input logic [127:0] u,
                                           input logic [4:0] k);
      logic [6:0] pos;
      pos = 7'({2'b00, 5'(UDID_NBYTES - k)} << 3);
      return u[pos +: 8];
   endfunction

   // ****************************************
   // Identifier assembly and bus events
   // ****************************************
   assign udid = {UDID_CAP,
                  VER_REV,
                  VENDOR_ID, DEVICE_ID,
                  UDID_IFACE,
                  UDID_SUBSYS,
                  UDID_VS_PAD, r.strap_position_bits, r.rnd};
   assign addr_byte = r.av ? {r.my_addr, 1'b1} : NO_ADDR_BYTE;
   assign rx_byte = {r.sh[6:0], sda_s};
   assign tx_idx = (r.st == S_TXACK) ? 5'(r.bidx + 5'h01) : 5'h00;
   assign start = r.scl_q && scl_s && r.sda_q && !sda_s;
   assign stop = r.scl_q && scl_s && !r.sda_q && sda_s;
   assign rise = !r.scl_q && scl_s;
   assign fall = r.scl_q && !scl_s;

   always_comb begin
      if (tx_idx == 5'h00) begin
         tx_byte = UDID_COUNT;
      end else if (tx_idx <= UDID_NBYTES) begin
         tx_byte = udid_sel(udid, tx_idx);
      end else if (tx_idx == IDX_TX_ADDR) begin
         tx_byte = addr_byte;
      end else if (tx_idx == IDX_TX_PEC) begin
         tx_byte = r.crc;
      end else begin
         tx_byte = IDLE_BYTE;
      end
   end

   // Broadcast set first, directed form only with a valid own address
   assign cmd_valid = (rx_byte == CMD_PREPARE) ||
                      (rx_byte == CMD_RESET_GEN) ||
                      (rx_byte == CMD_GET_GEN) ||
                      (rx_byte == CMD_ASSIGN && !r.fd_mode) ||
                      (rx_byte[7:1] == r.my_addr && r.av);

   always_comb begin
      r_nxt = r;
      r_nxt.scl_q = scl_s;
      r_nxt.sda_q = sda_s;
      r_nxt.lfsr = {r.lfsr[14:0], ^(r.lfsr & LFSR_TAPS)};

      // ****************************************
      // Power-up strap capture
      // ****************************************
      if (!r.strap_done) begin
         if (r.settle == STRAP_SETTLE) begin
            r_nxt.strap_done = 1'b1;
            r_nxt.fd_mode = !strap_s[2];
            r_nxt.strap_position_bits = strap_s[2] ? strap_s : 3'h0;
            r_nxt.my_addr = strap_s[2] ? 7'h00 :
                            (FD_ADDR_BASE | {5'h00, strap_s[1:0]});
            r_nxt.av = !strap_s[2];
         end else begin
            r_nxt.settle = 2'(r.settle + 2'h1);
         end
      end

      // ****************************************
      // Register slave, one wait state
      // ****************************************
      r_nxt.wreq = 1'b1;
      if ((avs_read || avs_write) && r.wreq) begin
         r_nxt.wreq = 1'b0;
         r_nxt.rdata = 32'h0000_0000;
         if (avs_read) begin
            if (avs_address == REG_CTRL) begin
               r_nxt.rdata[CTRL_EN] = r.resp_en;
            end else if (avs_address == REG_STATUS) begin
               r_nxt.rdata[ST_FD] = r.fd_mode;
               r_nxt.rdata[ST_AR] = r.ar;
               r_nxt.rdata[ST_AV] = r.av;
               r_nxt.rdata[ST_STRAP_DONE] = r.strap_done;
               r_nxt.rdata[ST_LVL +: 3] = r.strap_position_bits;
               r_nxt.rdata[ST_PEC_ERR] = r.pec_err;
               r_nxt.rdata[ST_ADDR +: 7] = r.my_addr;
               r_nxt.rdata[ST_RND_DONE] = r.rnd_done;
            end else if (avs_address == REG_RAND) begin
               r_nxt.rdata[15:0] = r.rnd;
            end
         end
      end
      if (avs_write && !r.wreq) begin
         if (avs_address == REG_CTRL && avs_byteenable[0]) begin
            r_nxt.resp_en = avs_writedata[CTRL_EN];
         end else if (avs_address == REG_STATUS && avs_byteenable[0]) begin
            if (avs_writedata[ST_PEC_ERR]) begin
               r_nxt.pec_err = 1'b0;
            end
         end
      end

      // ****************************************
      // Serial engine
      // ****************************************
      if (start) begin
         if (r.strap_done && r.resp_en) begin
            r_nxt.st = S_RX;
            r_nxt.bitcnt = 3'h0;
            r_nxt.addrph = 1'b1;
            r_nxt.got8 = 1'b0;
            r_nxt.sda_oe_n = 1'b1;
            if (!r.in_xfer) begin
               r_nxt.crc = 8'h00;
            end
            r_nxt.in_xfer = 1'b1;
            if (!r.rnd_done) begin
               r_nxt.rnd = r.lfsr;
               r_nxt.rnd_done = 1'b1;
            end
         end
      end else if (stop) begin
         r_nxt.st = S_IDLE;
         r_nxt.sda_oe_n = 1'b1;
         r_nxt.in_xfer = 1'b0;
         if (r.in_xfer && !r.rd && r.cmd_ok) begin
            if (r.cmd == CMD_ASSIGN && r.bidx == IDX_ASN_END) begin
               if (!r.pec_ok) begin
                  r_nxt.pec_err = 1'b1;
               end else if (r.match && !r.fd_mode) begin
                  r_nxt.my_addr = r.new_addr;
                  r_nxt.ar = 1'b1;
                  r_nxt.av = 1'b1;
               end
            end else if (r.cmd != CMD_ASSIGN && r.bidx == IDX_GEN_END) begin
               if (!r.pec_ok) begin
                  r_nxt.pec_err = 1'b1;
               end else if (r.cmd == CMD_PREPARE) begin
                  r_nxt.ar = 1'b0;
               end else if (r.cmd == CMD_RESET_GEN ||
                            r.cmd == {r.my_addr, 1'b0}) begin
                  r_nxt.ar = 1'b0;
                  r_nxt.av = r.fd_mode;
               end
            end
         end
      end else begin
         case (r.st)
            S_RX: begin
               if (rise) begin
                  r_nxt.sh = rx_byte;
                  r_nxt.bitcnt = 3'(r.bitcnt + 3'h1);
                  if (r.bitcnt == 3'h7) begin
                     r_nxt.got8 = 1'b1;
                     r_nxt.crc = crc_rx;
                     r_nxt.ackgo = 1'b0;
                     if (r.addrph) begin
                        r_nxt.addrph = 1'b0;
                        if (rx_byte[7:1] == ARP_ADDR && !rx_byte[0]) begin
                           r_nxt.ackgo = 1'b1;
                           r_nxt.rd = 1'b0;
                           r_nxt.bidx = 5'h00;
                           r_nxt.cmd_ok = 1'b0;
                           r_nxt.match = 1'b1;
                        end else if (rx_byte[7:1] == ARP_ADDR &&
                                     r.cmd_ok && r.bidx == IDX_CNT &&
                                     ((r.cmd == CMD_GET_GEN && !r.ar) ||
                                      r.cmd == {r.my_addr, 1'b1})) begin
                           r_nxt.ackgo = 1'b1;
                           r_nxt.rd = 1'b1;
                        end
                     end else begin
                        r_nxt.pec_ok = (crc_rx == 8'h00);
                        r_nxt.bidx = 5'(r.bidx + 5'h01);
                        if (r.bidx == 5'h00) begin
                           r_nxt.cmd = rx_byte;
                           r_nxt.cmd_ok = cmd_valid;
                           r_nxt.ackgo = cmd_valid;
                        end else begin
                           r_nxt.ackgo = r.cmd_ok &&
                              (r.bidx < ((r.cmd == CMD_ASSIGN) ?
                                         IDX_ASN_END : IDX_GEN_END));
                           if (r.bidx == IDX_CNT) begin
                              r_nxt.match = r.match &&
                                            (rx_byte == UDID_COUNT);
                           end else if (r.bidx <= IDX_UDID_LAST) begin
                              r_nxt.match = r.match && (rx_byte ==
                                 udid_sel(udid, 5'(r.bidx - 5'h01)));
                           end else if (r.bidx == IDX_ASN_ADDR) begin
                              r_nxt.new_addr = rx_byte[7:1];
                           end
                        end
                     end
                  end
               end else if (fall && r.got8) begin
                  r_nxt.got8 = 1'b0;
                  r_nxt.bitcnt = 3'h0;
                  if (r.ackgo) begin
                     r_nxt.sda_oe_n = 1'b0;
                     r_nxt.st = S_RXACK;
                  end else begin
                     r_nxt.st = S_IDLE;
                  end
               end
            end
            S_RXACK: begin
               if (fall) begin
                  r_nxt.sda_oe_n = 1'b1;
                  r_nxt.st = S_RX;
                  if (r.rd) begin
                     r_nxt.st = S_TX;
                     r_nxt.bidx = 5'h00;
                     r_nxt.tx = tx_byte;
                     r_nxt.crc = crc_tx;
                     r_nxt.sda_oe_n = tx_byte[7];
                  end
               end
            end
            S_TX: begin
               if (rise) begin
                  // Released high but line low: another device won
                  if (r.sda_oe_n && !sda_s) begin
                     r_nxt.st = S_IDLE;
                  end else begin
                     r_nxt.bitcnt = 3'(r.bitcnt + 3'h1);
                  end
               end else if (fall) begin
                  if (r.bitcnt == 3'h0) begin
                     r_nxt.sda_oe_n = 1'b1;
                     r_nxt.st = S_TXACK;
                  end else begin
                     r_nxt.tx = {r.tx[6:0], 1'b0};
                     r_nxt.sda_oe_n = r.tx[6];
                  end
               end
            end
            S_TXACK: begin
               if (rise) begin
                  r_nxt.got8 = !sda_s;
               end else if (fall) begin
                  r_nxt.got8 = 1'b0;
                  r_nxt.st = S_IDLE;
                  if (r.got8) begin
                     r_nxt.st = S_TX;
                     r_nxt.bidx = tx_idx;
                     r_nxt.tx = tx_byte;
                     r_nxt.crc = crc_tx;
                     r_nxt.sda_oe_n = tx_byte[7];
                  end
               end
            end
            default: begin
               r_nxt.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
         r.st <= S_IDLE;
         r.scl_q <= 1'b1;
         r.sda_q <= 1'b1;
         r.sda_oe_n <= 1'b1;
         r.wreq <= 1'b1;
         r.resp_en <= CTRL_EN_RESET;
         r.lfsr <= LFSR_SEED;
      end else begin
         r <= r_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign sda_out = r.sda_out;
   assign sda_oe_n = r.sda_oe_n;
   assign avs_readdata = r.rdata;
   assign avs_waitrequest = r.wreq;
   assign fixed_discoverable_mode = r.fd_mode;
   assign slave_addr = r.my_addr;
   assign addr_valid = r.av;
endmodule

// ==== smbarp_udid_sva.sv ====
// Checker of the identity block port behaviour
`timescale 1ns/1ps
module smbarp_udid_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic fixed_discoverable_mode,
   input wire logic [6:0] slave_addr
);
   // ****
   // Port relations
   // ****
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   property p_ans;
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_ans: assert property (p_ans) else $error("late answer");
   property p_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_one: assert property (p_one) else $error("long answer");
   property p_hold;
      !avs_read && !avs_write |=> $stable(avs_readdata);
   endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_keep;
      fixed_discoverable_mode |=> fixed_discoverable_mode;
   endproperty
   a_keep: assert property (p_keep) else $error("mode moved");
   property p_fix;
      fixed_discoverable_mode |=> slave_addr[6:2] == 5'h14;
   endproperty
   a_fix: assert property (p_fix) else $error("bad address");
   property p_lock;
      fixed_discoverable_mode && $past(fixed_discoverable_mode)
         |=> $stable(slave_addr);
   endproperty
   a_lock: assert property (p_lock) else $error("address moved");
   // Address may only move once the bus has gone idle after a stop
   property p_stop;
      !fixed_discoverable_mode && $changed(slave_addr) |-> scl_in && sda_in;
   endproperty
   a_stop: assert property (p_stop) else $error("early change");
   property p_low;
      $fell(sda_oe_n) |-> !scl_in;
   endproperty
   a_low: assert property (p_low) else $error("drive on high");
endmodule
bind smbarp_udid smbarp_udid_sva i_smbarp_udid_sva (.clk(clk),
   .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .fixed_discoverable_mode(fixed_discoverable_mode),
   .slave_addr(slave_addr));

// ==== smbarp_host.sv ====
// Behavioural SMBus host for address-resolution exchanges
`timescale 1ns/1ps
module smbarp_host (
   input wire logic clk,
   input wire logic sda_w,
   output logic scl,
   output logic sda
);
   // ****
   // Bus sequencing
   // ****
   logic [7:0] pec = 8'h00;
   logic nak = 1'b0;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic drv(input logic c, input logic d, input int n);
      {scl, sda} <= {c, d};
      repeat (n) @(posedge clk);
   endtask
   // Data moves two clocks after the fall, before the device drives
   task automatic bt(input logic b, output logic o);
      drv(1'b0, b, 10);
      drv(1'b1, b, 10);
      o = sda_w;
      drv(1'b0, b, 2);
   endtask
   task automatic crc(input logic [7:0] d);
      pec = pec ^ d;
      for (int i = 0; i < 8; i++) begin
         pec = {pec[6:0], 1'b0} ^ (pec[7] ? 8'h07 : 8'h00);
      end
   endtask
   task automatic start(input logic clr);
      drv(scl, 1'b1, 10);
      drv(1'b1, 1'b1, 10);
      drv(1'b1, 1'b0, 10);
      drv(1'b0, 1'b0, 2);
      if (clr) begin
         {pec, nak} = 9'h000;
      end
   endtask
   task automatic stop();
      drv(1'b0, 1'b0, 10);
      drv(1'b1, 1'b0, 10);
      drv(1'b1, 1'b1, 10);
   endtask
   task automatic wr(input logic [7:0] d);
      logic o;
      for (int i = 7; i >= 0; i--) bt(d[i], o);
      bt(1'b1, o);
      nak = nak | o;
      crc(d);
   endtask
   task automatic rd(input logic last, output logic [7:0] q);
      logic o;
      for (int i = 0; i < 8; i++) begin
         bt(1'b1, o);
         q = {q[6:0], o};
      end
      bt(last, o);
      crc(q);
   endtask
endmodule

// ==== smbarp_udid_tb.sv ====
// Self-checking bench for the address-resolution identity block
`timescale 1ns/1ps
module smbarp_udid_tb
   import smbarp_pkg::*;
;
   // ****
   // Bench
   // ****
   localparam logic [7:0] VR = 8'h12; // Arbitrary value
   localparam logic [15:0] VID = 16'h2468; // Arbitrary value
   localparam logic [15:0] DID = 16'h1357; // Arbitrary value
   logic clk;
   logic reset = 1'b1;
   logic [2:0] strap = 3'h0;
   logic [3:0] adr = 4'h0;
   logic rdq = 1'b0;
   logic wrq = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdata, q, rnd;
   logic wreq, oe_n, fixd, av, scl, hsda, sdo;
   logic [3:0] be = 4'hf;
   logic [6:0] sa;
   logic [127:0] u, u0;
   logic [7:0] cnt, ab;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   // Open drain: the pin follows sda_out only while enabled
   wire sda_w = hsda & (oe_n | sdo);
   smbarp_udid #(.VER_REV(VR), .VENDOR_ID(VID), .DEVICE_ID(DID))
      i_smbarp_udid (.clk(clk), .reset(reset), .scl_in(scl),
      .sda_in(sda_w), .sda_out(sdo), .sda_oe_n(oe_n),
      .strap_level_input(strap), .avs_address(adr), .avs_read(rdq),
      .avs_write(wrq), .avs_writedata(wd), .avs_byteenable(be),
      .avs_readdata(rdata), .avs_waitrequest(wreq),
      .fixed_discoverable_mode(fixd), .slave_addr(sa), .addr_valid(av));
   smbarp_host i_host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(hsda));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         test_done();
      end
   end
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic ck(input logic [127:0] g, input logic [127:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic avio(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
      @(posedge clk);
      {adr, wd, wrq, rdq} <= {a, d, w, !w};
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      q = rdata;
      {wrq, rdq} <= 2'b00;
   endtask
   task automatic rst(input logic [2:0] s);
      @(posedge clk);
      {reset, strap} <= {1'b1, s};
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   task automatic send(input logic [7:0] c);
      i_host.start(1'b1);
      i_host.wr({ARP_ADDR, 1'b0});
      i_host.wr(c);
      i_host.wr(i_host.pec);
      i_host.stop();
   endtask
   task automatic get(input logic [7:0] c);
      i_host.start(1'b1);
      i_host.wr({ARP_ADDR, 1'b0});
      i_host.wr(c);
      i_host.start(1'b0);
      i_host.wr({ARP_ADDR, 1'b1});
      i_host.rd(1'b0, cnt);
      for (int i = 0; i < 16; i++) begin
         i_host.rd(1'b0, ab);
         u = {u[119:0], ab};
      end
      i_host.rd(1'b0, ab);
      i_host.rd(1'b1, q[7:0]);
      i_host.stop();
      ck(cnt, 8'h11);
      ck({i_host.nak, i_host.pec}, 9'h000);
   endtask
   task automatic asn(input logic [6:0] a, input logic bad);
      i_host.start(1'b1);
      i_host.wr({ARP_ADDR, 1'b0});
      i_host.wr(CMD_ASSIGN);
      i_host.wr(8'h11);
      for (int i = 15; i >= 0; i--) i_host.wr(u0[i*8 +: 8]);
      i_host.wr({a, 1'b0});
      i_host.wr(i_host.pec ^ {7'h00, bad});
      i_host.stop();
      repeat (8) @(posedge clk);
   endtask
   task automatic t_strap();
      for (int s = 0; s < 8; s++) begin
         rst(s[2:0]);
         strap <= ~s[2:0];
         avio(1'b0, REG_STATUS, 32'h0);
         ck({fixd, q[0], q[3]}, {s < 4, s < 4, 1'b1});
         ck(q[6:4], (s > 3) ? s[2:0] : 3'h0);
         ck({sa, q[14:8]}, {2{(s < 4) ? {5'h14, s[1:0]} : 7'h00}});
      end
      avio(1'b0, 4'hc, 32'h0);
      ck(q, 32'h0);
   endtask
   task automatic t_arp();
      rst(3'h6);
      send(CMD_PREPARE);
      ck(i_host.nak, 1'b0);
      get(CMD_GET_GEN);
      u0 = u;
      ck(ab, 8'hff);
      avio(1'b0, REG_RAND, 32'h0);
      rnd = q;
      ck(u[127:64], {8'hc1, VR, VID, DID, 16'h0004});
      ck(u[63:0], {45'h0, 3'h6, rnd[15:0]});
      get(CMD_GET_GEN);
      ck(u, u0);
      asn(7'h2a, 1'b1);
      avio(1'b0, REG_STATUS, 32'h0);
      ck({av, q[7]}, 2'b01);
      avio(1'b1, REG_STATUS, 32'h80);
      avio(1'b0, REG_STATUS, 32'h0);
      ck(q[7], 1'b0);
      asn(7'h2a, 1'b0);
      ck({i_host.nak, av, sa}, {2'b01, 7'h2a});
      get({7'h2a, 1'b1});
      ck({ab, u}, {7'h2a, 1'b1, u0});
      send({7'h2a, 1'b0});
      repeat (8) @(posedge clk);
      ck({i_host.nak, av}, 2'b00);
      send(CMD_RESET_GEN);
      ck(i_host.nak, 1'b0);
   endtask
   task automatic t_fixed();
      rst(3'h2);
      send(CMD_PREPARE);
      asn(7'h2a, 1'b0);
      ck({i_host.nak, sa}, {1'b1, 7'h52});
      get(CMD_GET_GEN);
      ck({ab, u[127:120], u[18:16]}, {8'ha5, 8'hc1, 3'h0});
      // Lane 0 off: the enable write must be dropped
      be <= 4'he;
      avio(1'b1, REG_CTRL, 32'h0);
      be <= 4'hf;
      avio(1'b0, REG_CTRL, 32'h0);
      ck(q[0], 1'b1);
      avio(1'b1, REG_CTRL, 32'h0);
      send(CMD_PREPARE);
      ck(i_host.nak, 1'b1);
      avio(1'b1, REG_CTRL, 32'h1);
      send(CMD_RESET_GEN);
      ck({i_host.nak, av, sa}, {2'b01, 7'h52});
   endtask
   initial begin
      t_strap();
      t_arp();
      t_fixed();
      test_done();
   end
endmodule
